// ### hw/dbpt_pkg.sv
// constants shared by the dual bus packet transfer block
package dbpt_pkg;
  localparam int unsigned WORD_W      = 16;
  localparam int unsigned ADDR_W      = 23;
  localparam int unsigned CNT_W       = 16;
  localparam int unsigned NODE_W      = 4;
  localparam int unsigned NODES       = 16;
  localparam int unsigned NBUS        = 2;
  // packet layout
  localparam int unsigned PKT_WORDS   = 16;
  localparam int unsigned DATA_WORDS  = 13;
  localparam int unsigned DATA_BYTES  = 26;
  localparam int unsigned IDX_ROUTE   = 0;
  localparam int unsigned IDX_SEQ     = 1;
  localparam int unsigned IDX_DATA0   = 2;
  localparam int unsigned IDX_CSUM    = 15;
  // routing word fields
  localparam int unsigned RT_DST_LSB  = 0;
  localparam int unsigned RT_SRC_LSB  = 4;
  // bus rate: 13.33 MB/s of 16-bit words on a 10 MHz clock
  localparam int unsigned BUS_RATE_KBPS = 13330;
  localparam int unsigned CLK_KHZ       = 10000;
  localparam int unsigned BYTES_PER_WD  = 2;
  // window rounds down: rounding up gives 4 cycles and a slow bus
  localparam int unsigned PACE_WORDS  = 2;
  localparam int unsigned PACE_CYC    = (PACE_WORDS * BYTES_PER_WD * CLK_KHZ) / BUS_RATE_KBPS;
  localparam logic [15:0] CSUM_INIT   = 16'h0000;
endpackage : dbpt_pkg

// ### hw/dbpt_rx_buf.sv
// one bus receive buffer: 16-word packet store with running checksum
`timescale 1ns/100ps
`default_nettype none
module dbpt_rx_buf #(
  parameter int unsigned W     = dbpt_pkg::WORD_W,
  parameter int unsigned DEPTH = dbpt_pkg::PKT_WORDS
) (
  // clock and reset
  input  wire logic                     mclk_in,
  input  wire logic                     rst_b_in,
  // bus side
  input  wire logic                     wr_valid_in,
  input  wire logic                     wr_sop_in,
  input  wire logic [W-1:0]             wr_data_in,
  // engine side
  input  wire logic                     clear_in,
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx_in,
  output logic [W-1:0]                  rd_data_out,
  output logic                          full_out,
  output logic                          csum_ok_out
);
  if (DEPTH != dbpt_pkg::PKT_WORDS || W != dbpt_pkg::WORD_W) begin : g_chk
    $error("dbpt_rx_buf: unsupported size");
  end

  logic [W-1:0]             mem_r [DEPTH];
  logic [$clog2(DEPTH)-1:0] wptr_r;
  logic [W-1:0]             acc_r;
  logic                     full_r;
  logic                     ok_r;

  // a full buffer ignores the bus until the engine has drained it
  wire take = wr_valid_in && !full_r;

  always_ff @(posedge mclk_in) begin
    if (take) begin
      mem_r[wr_sop_in ? '0 : wptr_r] <= wr_data_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wptr_r <= '0;
      acc_r  <= dbpt_pkg::CSUM_INIT;
      full_r <= 1'b0;
      ok_r   <= 1'b0;
    end else if (clear_in) begin
      wptr_r <= '0;
      acc_r  <= dbpt_pkg::CSUM_INIT;
      full_r <= 1'b0;
    end else if (take) begin
      if (wr_sop_in) begin
        wptr_r <= $clog2(DEPTH)'(1);
        acc_r  <= wr_data_in;
      end else if (wptr_r == $clog2(DEPTH)'(DEPTH - 1)) begin
        full_r <= 1'b1;
        ok_r   <= (acc_r == wr_data_in);
        wptr_r <= '0;
      end else begin
        wptr_r <= wptr_r + $clog2(DEPTH)'(1);
        acc_r  <= acc_r ^ wr_data_in;
      end
    end
  end

  assign rd_data_out = mem_r[rd_idx_in];
  assign full_out    = full_r;
  assign csum_ok_out = ok_r;
endmodule // dbpt_rx_buf
`default_nettype wire

// ### hw/dbpt_top.sv
// dual bus packet transfer: block send, two receive buffers, routing table, drain engine
//
// Behaviour
// - two buses work independently and may carry transfers at the same time.
// - each bus carries 13.33 megabytes per second.
// - packets of different transfers interleave on a bus, one packet per grant.
// - transfers start only on the block-send instruction; receivers never initiate.
// - one send moves 1 to 64k-1 bytes to one destination on one bus.
// - packet is routing word, sequence word, 13 data words, checksum word.
// - each arriving packet is checked for transmission errors before memory write.
// - each bus has its own 16-word receive buffer fed only by it.
// - buffers fill alongside microcode; a full buffer triggers the drain routine.
// - routing table has 16 entries, one per source module.
// - entry holds expected sequence, buffer address and bytes still expected.
// - when expected bytes all arrived, the running process is interrupted.
// - unprivileged send traps the issuing process when no send is busy, and otherwise does nothing.
// - moving received data into memory is invisible to the running process.
`timescale 1ns/100ps
`default_nettype none
module dbpt_top (
  // clock and reset
  input  wire logic                   mclk_in,
  input  wire logic                   rst_b_in,
  input  wire logic [3:0]             own_id_in,
  // send instruction
  input  wire logic                   send_go_in,
  input  wire logic                   send_priv_in,
  input  wire logic                   send_bus_in,
  input  wire logic [3:0]             send_dst_in,
  input  wire logic [15:0]            send_seq_in,
  input  wire logic [22:0]            send_addr_in,
  input  wire logic [15:0]            send_cnt_in,
  output logic                        send_busy_out,
  output logic                        send_done_out,
  output logic                        send_trap_out,
  // routing table maintenance
  input  wire logic                   tbl_we_in,
  input  wire logic [3:0]             tbl_idx_in,
  input  wire logic [15:0]            tbl_seq_in,
  input  wire logic [22:0]            tbl_addr_in,
  input  wire logic [15:0]            tbl_cnt_in,
  // process notification
  output logic                        msg_done_out,
  output logic [3:0]                  msg_src_out,
  output logic                        pkt_drop_out,
  // memory port
  output logic                        mem_req_out,
  output logic                        mem_we_out,
  output logic [22:0]                 mem_addr_out,
  output logic [15:0]                 mem_wdata_out,
  input  wire logic [15:0]            mem_rdata_in,
  input  wire logic                   mem_ack_in,
  // buses, index 0 is the first bus, 1 the second
  input  wire logic [1:0]             bus_rx_valid_in,
  input  wire logic [1:0]             bus_rx_sop_in,
  input  wire logic [1:0][15:0]       bus_rx_data_in,
  output logic [1:0]                  bus_rx_full_out,
  output logic [1:0]                  bus_req_out,
  input  wire logic [1:0]             bus_gnt_in,
  output logic [1:0]                  bus_tx_valid_out,
  output logic [1:0]                  bus_tx_sop_out,
  output logic [1:0][15:0]            bus_tx_data_out
);
  typedef enum logic [2:0] {
    ENG_IDLE  = 3'b000,
    ENG_CHECK = 3'b001,
    ENG_WR    = 3'b010,
    ENG_UPD   = 3'b011,
    ENG_RD    = 3'b100
  } dbpt_eng_e;

  typedef enum logic [1:0] {
    SND_IDLE = 2'b00,
    SND_LOAD = 2'b01,
    SND_REQ  = 2'b10,
    SND_XMIT = 2'b11
  } dbpt_snd_e;

  ////////////////////////////////////////////////////////////////////////////
  // receive buffers, one per bus
  logic [1:0]       full;
  logic [1:0]       csum_ok;
  logic [1:0][15:0] rd_data;
  logic [1:0]       clear_r;
  logic [3:0]       rd_idx_r;

  for (genvar b = 0; b < 2; b++) begin : g_rx
    dbpt_rx_buf u_buf (
      .mclk_in     (mclk_in),
      .rst_b_in    (rst_b_in),
      .wr_valid_in (bus_rx_valid_in[b]),
      .wr_sop_in   (bus_rx_sop_in[b]),
      .wr_data_in  (bus_rx_data_in[b]),
      .clear_in    (clear_r[b]),
      .rd_idx_in   (rd_idx_r),
      .rd_data_out (rd_data[b]),
      .full_out    (full[b]),
      .csum_ok_out (csum_ok[b])
    );
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) bus_rx_full_out <= 2'b00;
    else           bus_rx_full_out <= full & ~clear_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // routing table, one entry per source module
  logic [15:0] tbl_seq_r  [dbpt_pkg::NODES];
  logic [22:0] tbl_addr_r [dbpt_pkg::NODES];
  logic [15:0] tbl_cnt_r  [dbpt_pkg::NODES];

  ////////////////////////////////////////////////////////////////////////////
  // drain and load engine, stands for the microroutine
  dbpt_eng_e   eng_r;
  logic        sel_r;
  logic [3:0]  src_r;
  logic [3:0]  nwd_r;
  logic [15:0] take_r;
  logic        load_done_r;
  logic [15:0] txbuf_r [dbpt_pkg::PKT_WORDS];
  dbpt_snd_e   snd_r;
  logic [22:0] snd_addr_r;
  logic [15:0] snd_cnt_r;
  logic [15:0] snd_seq_r;
  logic [3:0]  snd_dst_r;
  logic        snd_bus_r;

  wire [15:0] rt_word  = rd_data[sel_r];
  wire [3:0]  rt_src   = rt_word[dbpt_pkg::RT_SRC_LSB +: 4];
  wire [3:0]  rt_dst   = rt_word[dbpt_pkg::RT_DST_LSB +: 4];
  wire [15:0] ent_cnt  = tbl_cnt_r[src_r];
  wire        big      = ent_cnt >= 16'(dbpt_pkg::DATA_BYTES);
  wire [15:0] snd_take = (snd_cnt_r >= 16'(dbpt_pkg::DATA_BYTES)) ? 16'(dbpt_pkg::DATA_BYTES) : snd_cnt_r;
  wire [3:0]  snd_nwd  = 4'((snd_take + 16'h0001) >> 1);
  wire        mem_done = mem_req_out && mem_ack_in;
  wire        last_wd  = (rd_idx_r == 4'(dbpt_pkg::IDX_DATA0) + nwd_r - 4'h1);

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      eng_r         <= ENG_IDLE;
      sel_r         <= 1'b0;
      src_r         <= 4'h0;
      nwd_r         <= 4'h0;
      take_r        <= 16'h0000;
      rd_idx_r      <= 4'h0;
      clear_r       <= 2'b00;
      load_done_r   <= 1'b0;
      mem_req_out   <= 1'b0;
      mem_we_out    <= 1'b0;
      mem_addr_out  <= 23'h00_0000;
      mem_wdata_out <= 16'h0000;
      msg_done_out  <= 1'b0;
      msg_src_out   <= 4'h0;
      pkt_drop_out  <= 1'b0;
    end else begin
      clear_r      <= 2'b00;
      load_done_r  <= 1'b0;
      msg_done_out <= 1'b0;
      pkt_drop_out <= 1'b0;
      case (eng_r)
        ENG_IDLE: begin
          rd_idx_r <= 4'(dbpt_pkg::IDX_ROUTE);
          // a full buffer pre-empts send loading; runs beside the process
          if (full[0] && !clear_r[0]) begin
            sel_r <= 1'b0;
            eng_r <= ENG_CHECK;
          end else if (full[1] && !clear_r[1]) begin
            sel_r <= 1'b1;
            eng_r <= ENG_CHECK;
          end else if (snd_r == SND_LOAD && !load_done_r) begin
            rd_idx_r     <= 4'(dbpt_pkg::IDX_DATA0);
            nwd_r        <= snd_nwd;
            mem_req_out  <= 1'b1;
            mem_we_out   <= 1'b0;
            mem_addr_out <= snd_addr_r;
            eng_r        <= ENG_RD;
          end
        end
        ENG_CHECK: begin
          if (rd_idx_r == 4'(dbpt_pkg::IDX_ROUTE)) begin
            src_r    <= rt_src;
            rd_idx_r <= 4'(dbpt_pkg::IDX_SEQ);
            if (!csum_ok[sel_r] || rt_dst != own_id_in) begin
              clear_r[sel_r] <= 1'b1;
              pkt_drop_out   <= 1'b1;
              eng_r          <= ENG_IDLE;
            end
          end else if (rt_word != tbl_seq_r[src_r] || ent_cnt == 16'h0000) begin
            clear_r[sel_r] <= 1'b1;
            pkt_drop_out   <= 1'b1;
            eng_r          <= ENG_IDLE;
          end else begin
            take_r        <= big ? 16'(dbpt_pkg::DATA_BYTES) : ent_cnt;
            nwd_r         <= big ? 4'(dbpt_pkg::DATA_WORDS) : 4'((ent_cnt + 16'h0001) >> 1);
            rd_idx_r      <= 4'(dbpt_pkg::IDX_DATA0);
            // req rises in ENG_WR with the first word
            mem_we_out    <= 1'b1;
            mem_addr_out  <= tbl_addr_r[src_r];
            eng_r         <= ENG_WR;
          end
        end
        ENG_WR: begin
          mem_wdata_out <= rd_data[sel_r];
          if (mem_done) begin
            mem_req_out <= 1'b0;
            if (last_wd) begin
              eng_r <= ENG_UPD;
            end else begin
              rd_idx_r     <= rd_idx_r + 4'h1;
              mem_addr_out <= mem_addr_out + 23'h00_0001;
            end
          end else if (!mem_req_out) begin
            mem_req_out <= 1'b1;
          end
        end
        ENG_UPD: begin
          clear_r[sel_r] <= 1'b1;
          if (ent_cnt == take_r) begin
            msg_done_out <= 1'b1;
            msg_src_out  <= src_r;
          end
          eng_r <= ENG_IDLE;
        end
        ENG_RD: begin
          if (mem_done) begin
            mem_req_out <= 1'b0;
            if (last_wd) begin
              load_done_r <= 1'b1;
              eng_r       <= ENG_IDLE;
            end else begin
              rd_idx_r     <= rd_idx_r + 4'h1;
              mem_addr_out <= mem_addr_out + 23'h00_0001;
            end
          end else if (!mem_req_out) begin
            mem_req_out <= 1'b1;
          end
        end
        default: eng_r <= ENG_IDLE;
      endcase
    end
  end

  // routing table update; an engine update beats a same-cycle maintenance write
  always_ff @(posedge mclk_in) begin
    if (eng_r == ENG_UPD) begin
      tbl_seq_r[src_r]  <= tbl_seq_r[src_r] + 16'h0001;
      tbl_addr_r[src_r] <= tbl_addr_r[src_r] + 23'(nwd_r);
      tbl_cnt_r[src_r]  <= ent_cnt - take_r;
    end else if (tbl_we_in) begin
      tbl_seq_r[tbl_idx_in]  <= tbl_seq_in;
      tbl_addr_r[tbl_idx_in] <= tbl_addr_in;
      tbl_cnt_r[tbl_idx_in]  <= tbl_cnt_in;
    end
  end

  // staging packet for the send side
  always_ff @(posedge mclk_in) begin
    if (eng_r == ENG_RD && mem_done) begin
      txbuf_r[rd_idx_r] <= mem_rdata_in;
    end else if (snd_r == SND_LOAD && eng_r == ENG_IDLE && !load_done_r && !(|(full & ~clear_r))) begin
      // clear the data area so a short last packet is zero padded
      for (int i = dbpt_pkg::IDX_DATA0; i < dbpt_pkg::IDX_CSUM; i++) txbuf_r[i] <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // send side: one packet per bus grant, paced to the bus rate
  logic [3:0]  tx_idx_r;
  logic [1:0]  pace_r;
  logic [15:0] csum_r;
  wire         pace_en = (pace_r < 2'(dbpt_pkg::PACE_WORDS));
  wire [15:0]  tx_word = (tx_idx_r == 4'(dbpt_pkg::IDX_ROUTE)) ? {8'h00, own_id_in, snd_dst_r} :
                         (tx_idx_r == 4'(dbpt_pkg::IDX_SEQ))   ? snd_seq_r :
                         (tx_idx_r == 4'(dbpt_pkg::IDX_CSUM))  ? csum_r : txbuf_r[tx_idx_r];

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) pace_r <= 2'b00;
    else if (pace_r == 2'(dbpt_pkg::PACE_CYC - 1)) pace_r <= 2'b00;
    else pace_r <= pace_r + 2'b01;
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      snd_r            <= SND_IDLE;
      snd_addr_r       <= 23'h00_0000;
      snd_cnt_r        <= 16'h0000;
      snd_seq_r        <= 16'h0000;
      snd_dst_r        <= 4'h0;
      snd_bus_r        <= 1'b0;
      tx_idx_r         <= 4'h0;
      csum_r           <= dbpt_pkg::CSUM_INIT;
      send_busy_out    <= 1'b0;
      send_done_out    <= 1'b0;
      send_trap_out    <= 1'b0;
      bus_req_out      <= 2'b00;
      bus_tx_valid_out <= 2'b00;
      bus_tx_sop_out   <= 2'b00;
      bus_tx_data_out  <= '0;
    end else begin
      send_done_out    <= 1'b0;
      send_trap_out    <= 1'b0;
      bus_tx_valid_out <= 2'b00;
      bus_tx_sop_out   <= 2'b00;
      case (snd_r)
        SND_IDLE: begin
          if (send_go_in && !send_priv_in) begin
            send_trap_out <= 1'b1;
          end else if (send_go_in && send_cnt_in != 16'h0000) begin
            snd_addr_r    <= send_addr_in;
            snd_cnt_r     <= send_cnt_in;
            snd_seq_r     <= send_seq_in;
            snd_dst_r     <= send_dst_in;
            snd_bus_r     <= send_bus_in;
            send_busy_out <= 1'b1;
            snd_r         <= SND_LOAD;
          end else if (send_go_in) begin
            send_done_out <= 1'b1;
          end
        end
        SND_LOAD: begin
          if (load_done_r) begin
            bus_req_out[snd_bus_r] <= 1'b1;
            snd_r                  <= SND_REQ;
          end
        end
        SND_REQ: begin
          tx_idx_r <= 4'(dbpt_pkg::IDX_ROUTE);
          csum_r   <= dbpt_pkg::CSUM_INIT;
          if (bus_gnt_in[snd_bus_r]) snd_r <= SND_XMIT;
        end
        SND_XMIT: begin
          if (pace_en) begin
            bus_tx_valid_out[snd_bus_r] <= 1'b1;
            bus_tx_sop_out[snd_bus_r]   <= (tx_idx_r == 4'(dbpt_pkg::IDX_ROUTE));
            bus_tx_data_out[snd_bus_r]  <= tx_word;
            csum_r                      <= csum_r ^ tx_word;
            tx_idx_r                    <= tx_idx_r + 4'h1;
            if (tx_idx_r == 4'(dbpt_pkg::IDX_CSUM)) begin
              // release the bus after every packet so others interleave
              bus_req_out[snd_bus_r] <= 1'b0;
              snd_cnt_r              <= snd_cnt_r - snd_take;
              snd_addr_r             <= snd_addr_r + 23'(snd_nwd);
              snd_seq_r              <= snd_seq_r + 16'h0001;
              if (snd_cnt_r == snd_take) begin
                send_busy_out <= 1'b0;
                send_done_out <= 1'b1;
                snd_r         <= SND_IDLE;
              end else begin
                snd_r <= SND_LOAD;
              end
            end
          end
        end
        default: snd_r <= SND_IDLE;
      endcase
    end
  end
endmodule // dbpt_top
`default_nettype wire

// ### verification/dbpt_peer_model.sv
// peer module model: grants the bus and sends one 16-word packet per go
`timescale 1ns/100ps
`default_nettype none
module dbpt_peer_model (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  // packet order
  input  wire logic        go_in,
  input  wire logic        bad_in,
  input  wire logic [3:0]  src_in,
  input  wire logic [3:0]  dst_in,
  input  wire logic [15:0] seq_in,
  input  wire logic [15:0] dbase_in,
  output logic             busy_out,
  // bus lines
  input  wire logic        req_in,
  output logic             gnt_out,
  output logic             valid_out,
  output logic             sop_out,
  output logic [15:0]      data_out
);
  logic [4:0]  idx_r;
  logic [1:0]  pace_r;
  logic [15:0] csum_r;
  logic [15:0] word;
  assign busy_out = (idx_r != 5'h10);
  always_comb begin
    case (idx_r)
      5'h00:   word = {8'h00, src_in, dst_in};
      5'h01:   word = seq_in;
      5'h0f:   word = csum_r ^ {15'h0000, bad_in};
      default: word = dbase_in + 16'(idx_r - 5'h02);
    endcase
  end
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      {idx_r, pace_r, csum_r, gnt_out, valid_out, sop_out, data_out} <= {5'h10, 2'h0, 16'h0000, 3'h0, 16'h0000};
    end else begin
      // grant a cycle late, as a slow arbiter would
      gnt_out   <= req_in;
      pace_r    <= (pace_r == 2'h2) ? 2'h0 : pace_r + 2'h1;
      valid_out <= 1'b0;
      sop_out   <= 1'b0;
      // released lines keep toggling so stale data never looks valid
      data_out  <= ~data_out;
      if (go_in && !busy_out) begin
        idx_r  <= 5'h00;
        csum_r <= 16'h0000;
      end else if (busy_out && pace_r != 2'h2) begin
        valid_out <= 1'b1;
        sop_out   <= (idx_r == 5'h00);
        data_out  <= word;
        csum_r    <= csum_r ^ word;
        idx_r     <= idx_r + 5'h01;
      end
    end
  end
endmodule // dbpt_peer_model
`default_nettype wire

// ### verification/dbpt_top_checker.sv
// port checks of the dual bus packet transfer block
`timescale 1ns/100ps
`default_nettype none
module dbpt_top_checker (
  // clock and reset
  input wire logic             mclk_in,
  input wire logic             rst_b_in,
  // send
  input wire logic [3:0]       own_id_in,
  input wire logic             send_go_in,
  input wire logic             send_priv_in,
  input wire logic [15:0]      send_cnt_in,
  input wire logic             send_busy_out,
  input wire logic             send_done_out,
  input wire logic             send_trap_out,
  // receive and memory
  input wire logic             msg_done_out,
  input wire logic             pkt_drop_out,
  input wire logic             mem_req_out,
  input wire logic             mem_we_out,
  input wire logic [1:0]       bus_rx_full_out,
  // buses
  input wire logic [1:0]       bus_gnt_in,
  input wire logic [1:0]       bus_tx_valid_out,
  input wire logic [1:0]       bus_tx_sop_out,
  input wire logic [1:0][15:0] bus_tx_data_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  chk_trap_only: assert property (send_go_in && !send_busy_out && !send_priv_in |=> send_trap_out && !send_busy_out)
    else $error("unprivileged send not trapped");
  chk_go_busy: assert property (send_go_in && !send_busy_out && send_priv_in && send_cnt_in != 16'h0000 |=> ##[0:1] send_busy_out)
    else $error("accepted send not busy");
  chk_zero_done: assert property (send_go_in && !send_busy_out && send_priv_in && send_cnt_in == 16'h0000 |=> send_done_out)
    else $error("empty send gave no done");
  chk_one_bus: assert property (!(bus_tx_valid_out[0] && bus_tx_valid_out[1]))
    else $error("send on both buses");
  chk_tx_granted: assert property ((bus_tx_valid_out & ~bus_gnt_in) == 2'b00)
    else $error("word sent without grant");
  chk_bus_pace: assert property (|bus_tx_valid_out ##1 |bus_tx_valid_out |=> !(|bus_tx_valid_out))
    else $error("bus faster than two words in three cycles");
  chk_route_word: assert property (bus_tx_sop_out[0] |-> bus_tx_valid_out[0] && bus_tx_data_out[0][15:4] == {8'h00, own_id_in})
    else $error("bad routing word");
  chk_write_drain: assert property (mem_req_out && mem_we_out |-> bus_rx_full_out != 2'b00)
    else $error("memory write outside a drain");
  chk_drop_excl: assert property (!(msg_done_out && pkt_drop_out))
    else $error("dropped packet completed a message");
endmodule // dbpt_top_checker
bind dbpt_top dbpt_top_checker u_chk (.mclk_in, .rst_b_in, .own_id_in, .send_go_in, .send_priv_in, .send_cnt_in,
  .send_busy_out, .send_done_out, .send_trap_out, .msg_done_out, .pkt_drop_out, .mem_req_out, .mem_we_out,
  .bus_rx_full_out, .bus_gnt_in, .bus_tx_valid_out, .bus_tx_sop_out, .bus_tx_data_out);
`default_nettype wire

// ### verification/test_dbpt_top.sv
// self-checking bench of the dual bus packet transfer block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module test_dbpt_top;
  typedef struct {logic b; logic p; logic [15:0] c; int w, t, d;} dbpt_srow_s;
  typedef struct {logic b; logic [3:0] s, d; logic [15:0] q, db; logic bad; int wr, md, dr;} dbpt_rrow_s;
  logic        mclk_in = 1'b0, rst_b_in = 1'b0, go = 1'b0, priv = 1'b0, sbus = 1'b0, we = 1'b0, ack = 1'b0, rq_d = 1'b0;
  logic [3:0]  dst = 4'h0, tidx = 4'h0;
  logic [15:0] seq = 16'h0000, cnt = 16'h0000, tseq = 16'h0000, tcnt = 16'h0000, rdata = 16'h0000, mask, x;
  logic [22:0] addr = 23'h00_0000, taddr = 23'h00_0000;
  logic [1:0]  p_go = 2'b00, p_bad = 2'b00;
  logic [3:0]  p_src [2] = '{4'h0, 4'h0}, p_dst [2] = '{4'h0, 4'h0};
  logic [15:0] p_seq [2] = '{16'h0000, 16'h0000}, p_db [2] = '{16'h0000, 16'h0000};
  wire  [1:0]  p_busy, rx_v, rx_sop, gnt, full, req, tx_v, tx_sop;
  wire  [1:0][15:0] rx_d, tx_d;
  wire         busy, done, trap, msg, drop, mreq, mwe;
  wire  [3:0]  msrc;
  wire  [22:0] maddr;
  wire  [15:0] mwd;
  int miscompares = 0, n_compared = 0, txw, traps, dones, msgs, drops, wrs, k, pk;
  dbpt_srow_s sr [5] = '{'{1'b0, 1'b1, 16'h0001, 16, 0, 1}, '{1'b1, 1'b1, 16'h001a, 16, 0, 1},
    '{1'b0, 1'b1, 16'h0035, 48, 0, 1}, '{1'b1, 1'b0, 16'h0005, 0, 1, 0}, '{1'b0, 1'b1, 16'h0000, 0, 0, 1}};
  dbpt_rrow_s rr [4] = '{'{1'b0, 4'h3, 4'h9, 16'h0005, 16'h1000, 1'b0, 13, 0, 0},
    '{1'b0, 4'h5, 4'h9, 16'h0003, 16'h3000, 1'b0, 0, 0, 1}, '{1'b1, 4'h5, 4'h9, 16'h0002, 16'h3000, 1'b1, 0, 0, 1},
    '{1'b1, 4'h5, 4'h9, 16'h0002, 16'h3000, 1'b0, 13, 1, 0}};
  dbpt_top uut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .own_id_in(4'h9), .send_go_in(go), .send_priv_in(priv),
    .send_bus_in(sbus), .send_dst_in(dst), .send_seq_in(seq), .send_addr_in(addr), .send_cnt_in(cnt),
    .send_busy_out(busy), .send_done_out(done), .send_trap_out(trap), .tbl_we_in(we), .tbl_idx_in(tidx),
    .tbl_seq_in(tseq), .tbl_addr_in(taddr), .tbl_cnt_in(tcnt), .msg_done_out(msg), .msg_src_out(msrc),
    .pkt_drop_out(drop), .mem_req_out(mreq), .mem_we_out(mwe), .mem_addr_out(maddr), .mem_wdata_out(mwd),
    .mem_rdata_in(rdata), .mem_ack_in(ack), .bus_rx_valid_in(rx_v), .bus_rx_sop_in(rx_sop), .bus_rx_data_in(rx_d),
    .bus_rx_full_out(full), .bus_req_out(req), .bus_gnt_in(gnt), .bus_tx_valid_out(tx_v), .bus_tx_sop_out(tx_sop),
    .bus_tx_data_out(tx_d));
  for (genvar g = 0; g < 2; g++) begin : g_peer
    dbpt_peer_model peer (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .go_in(p_go[g]), .bad_in(p_bad[g]),
      .src_in(p_src[g]), .dst_in(p_dst[g]), .seq_in(p_seq[g]), .dbase_in(p_db[g]), .busy_out(p_busy[g]),
      .req_in(req[g]), .gnt_out(gnt[g]), .valid_out(rx_v[g]), .sop_out(rx_sop[g]), .data_out(rx_d[g]));
  end
  always #50 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    rq_d <= mreq;
    ack <= mreq && rq_d && !ack;
    rdata <= maddr[15:0] ^ 16'h5a5a;
  end
  always @(posedge mclk_in) begin
    txw += $countones(tx_v);
    traps += trap;
    dones += done;
    msgs += msg;
    drops += drop;
    if (msg) mask[msrc] = 1'b1;
    if (ack && mreq && mwe) begin
      wrs++;
      `CHK("write data", maddr[15:0], mwd)
    end
    if (tx_v[sbus]) begin
      k = tx_sop[sbus] ? 0 : k + 1;
      pk += (k == 0);
      if (k == 0) `CHK("route word", ({8'h00, 4'h9, dst}), tx_d[sbus])
      if (k == 1) `CHK("seq word", 16'(seq + pk), tx_d[sbus])
      if (k == 2 && cnt > 16'(26 * pk + 1)) `CHK("data word", 16'(addr + 13 * pk) ^ 16'h5a5a, tx_d[sbus])
      if (k == 15) `CHK("checksum", x, tx_d[sbus])
      x = (k == 0) ? tx_d[sbus] : x ^ tx_d[sbus];
    end
  end
  task automatic tick(int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task clr();
    {txw, traps, dones, msgs, drops, wrs, mask} = '0;
    pk = -1;
  endtask
  task wait_idle();
    int q;
    q = 0;
    for (int i = 0; i < 3000 && q < 4; i++) begin
      @(negedge mclk_in);
      q = (!busy && p_busy == 2'b00 && full == 2'b00 && !mreq) ? q + 1 : 0;
    end
  endtask
  task issue(logic b, logic p, logic [15:0] c, logic [15:0] q, logic [22:0] a, logic [3:0] d);
    @(posedge mclk_in);
    {sbus, priv, cnt, seq, addr, dst, go} <= {b, p, c, q, a, d, 1'b1};
    @(posedge mclk_in);
    go <= 1'b0;
  endtask
  task launch(dbpt_rrow_s r);
    {p_src[r.b], p_dst[r.b], p_seq[r.b], p_db[r.b], p_bad[r.b], p_go[r.b]} <= {r.s, r.d, r.q, r.db, r.bad, 1'b1};
  endtask
  task tw(logic [3:0] i, logic [15:0] q, logic [22:0] a, logic [15:0] c);
    @(posedge mclk_in);
    {we, tidx, tseq, taddr, tcnt} <= {1'b1, i, q, a, c};
    @(posedge mclk_in);
    we <= 1'b0;
  endtask
  task conclude();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge mclk_in);
    miscompares++;
    conclude();
  end
  initial begin
    clr();
    tick(6);
    rst_b_in <= 1'b1;
    // table is not reset, so every entry is written first
    for (int i = 0; i < 16; i++) tw(4'(i), 16'h0000, 23'h00_0000, 16'h0000);
    tw(4'h3, 16'h0005, 23'h00_1000, 16'h0028);
    tw(4'h4, 16'h0007, 23'h00_2000, 16'h000a);
    tw(4'h5, 16'h0002, 23'h00_3000, 16'h001a);
    foreach (sr[i]) begin
      clr();
      issue(sr[i].b, sr[i].p, sr[i].c, 16'h00f0 + 16'(i), 23'h00_0400 * 23'(i + 1), 4'(i + 1));
      wait_idle();
      `CHK("tx words", sr[i].w, txw)
      `CHK("traps", sr[i].t, traps)
      `CHK("send done", sr[i].d, dones)
    end
    foreach (rr[i]) begin
      clr();
      @(posedge mclk_in);
      launch(rr[i]);
      @(posedge mclk_in);
      p_go <= 2'b00;
      wait_idle();
      `CHK("memory writes", rr[i].wr, wrs)
      `CHK("messages done", rr[i].md, msgs)
      `CHK("packets dropped", rr[i].dr, drops)
    end
    clr();
    @(posedge mclk_in);
    launch('{1'b0, 4'h3, 4'h9, 16'h0006, 16'h100d, 1'b0, 0, 0, 0});
    launch('{1'b1, 4'h4, 4'h9, 16'h0007, 16'h2000, 1'b0, 0, 0, 0});
    @(posedge mclk_in);
    p_go <= 2'b00;
    wait_idle();
    `CHK("message sources", 16'h0018, mask)
    `CHK("dropped", 0, drops)
    clr();
    issue(1'b0, 1'b1, 16'h0035, 16'h0200, 23'h00_5000, 4'h2);
    tick(40);
    rst_b_in <= 1'b0;
    @(negedge mclk_in);
    `CHK("outputs in reset", 6'h00, ({busy, req, tx_v, mreq}))
    conclude();
  end
endmodule // test_dbpt_top
`default_nettype wire
